// file: src/bto_options.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
// Summary of operation
// - With bit 0 set, a delayed write completes only after target PERR# status is known.
// - With bit 1 set, a delayed read completes only after target PAR has been received.
// - With bit 2 set, delayed reads may complete out of request order, else in order.
// - With bit 3 set, forwarded parity is regenerated, else buffered parity is passed on.
// - Type 0 config cycles drive address for bits 6-4 clocks before FRAME# asserts.
// - With bit 9 set, prefetch stops early when another prefetchable read is accepted.
// - With bit 10 set, reads start only if buffer space covers the prefetch count.
// - Forced conversion issues 32-bit prefetch reads and posted writes as 64-bit cycles.
// - Bits 11 and 15 select conversion: off, secondary, both, or primary port.
// - With bit 12 set, MWI passes if a cache line is free, else becomes a memory write.
// - With bit 12 clear, MWI is retried when a cache line of space is not free.
// - Bit 13 enables LOCK on the primary port and resets to one.
// - Bit 14 enables LOCK on the secondary port and resets to zero.
module bto_options
  import bto_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        txn_accept,
  input  wire logic        txn_to_sec,
  input  wire logic        txn_is_read,
  input  wire logic        txn_is_32,
  input  wire logic        txn_prefetch,
  input  wire logic        txn_posted,
  input  wire logic        txn_is_mwi,
  input  wire logic        txn_tgt_64,
  input  wire logic [8:0]  buf_free_dw,
  input  wire logic [8:0]  prefetch_dw,
  input  wire logic        flow_through,
  input  wire logic        perr_known,
  input  wire logic        par_received,
  input  wire logic        cfg0_start,
  output logic             cfg0_frame_go,
  output logic             cfg0_busy,
  output logic             cmpl_release,
  output logic             fwd_gen_parity,
  output logic             rd_out_of_order,
  output logic             rd_start_ok,
  output logic             pf_stop,
  output logic             conv_64,
  output logic             mwi_pass,
  output logic             mwi_as_mw,
  output logic             mwi_retry,
  output logic             lock_en_pri,
  output logic             lock_en_sec
);
  typedef struct packed {
    logic [15:0] opt;
    logic [15:0] rdata;
    logic [15:0] tx_opt;
    logic        tx_valid;
    logic        tx_read;
    logic        tx_sec;
    logic        pf_active;
    logic        pf_stop;
    logic        conv;
    logic        mwi_pass;
    logic        mwi_mw;
    logic        mwi_retry;
  } bto_state_t;

  bto_state_t st, next_st;
  bto_step_if stp ();
  logic       f64_ok;

  bto_step_timer u_step (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .stp     (stp)
  );

  // Step count follows live options, since config cycles are issued from the register itself
  assign stp.start     = cfg0_start;
  assign stp.count     = st.opt[BTO_STEP_LSB +: BTO_STEP_W];
  assign cfg0_frame_go = stp.frame_go;
  assign cfg0_busy     = stp.busy;

  always_comb begin
    next_st       = st;
    next_st.rdata = '0;
    f64_ok        = 1'b0;
    if (reg_wr && reg_addr == BTO_OPT_OFFSET) begin
      // Bit 15 is writable; reserved bits 8:7 stay at zero
      next_st.opt = (st.opt & ~BTO_OPT_WMASK) | (reg_wdata & BTO_OPT_WMASK);
    end
    if (reg_rd) begin
      case (reg_addr)
        BTO_OPT_OFFSET:    next_st.rdata = st.opt;
        BTO_STATUS_OFFSET: next_st.rdata = {9'h000, st.pf_active, st.mwi_retry, st.mwi_mw,
                                            st.mwi_pass, st.conv, st.tx_read, st.tx_valid};
        default:           next_st.rdata = '0;
      endcase
    end
    // Flow-through ends the fill, but a prefetchable read accepted alongside starts a new one
    if (flow_through) begin
      next_st.pf_active = 1'b0;
      next_st.pf_stop   = 1'b0;
    end
    if (txn_accept) begin
      next_st.tx_opt   = st.opt;
      next_st.tx_valid = 1'b1;
      next_st.tx_read  = txn_is_read;
      next_st.tx_sec   = txn_to_sec;
      // Conversion direction chosen by bits 11 and 15
      case ({st.opt[BTO_F64_LO_BIT], st.opt[BTO_F64_HI_BIT]})
        2'b01:   f64_ok = txn_to_sec;
        2'b10:   f64_ok = 1'b1;
        2'b11:   f64_ok = !txn_to_sec;
        default: f64_ok = 1'b0;
      endcase
      next_st.conv = f64_ok && txn_is_32 && txn_tgt_64 &&
                     ((txn_is_read && txn_prefetch) || (!txn_is_read && txn_posted));
      next_st.mwi_pass  = 1'b0;
      next_st.mwi_mw    = 1'b0;
      next_st.mwi_retry = 1'b0;
      if (txn_is_mwi) begin
        if (buf_free_dw >= BTO_CACHE_LINE_DW) begin
          next_st.mwi_pass = 1'b1;
        end else if (st.opt[BTO_MWI_BIT]) begin
          next_st.mwi_mw = 1'b1;
        end else begin
          next_st.mwi_retry = 1'b1;
        end
      end
      // A second prefetchable read while one is still filling
      next_st.pf_stop = st.pf_active && txn_prefetch && txn_is_read &&
                        !flow_through && st.tx_opt[BTO_PF_EARLY_BIT];
      if (txn_prefetch && txn_is_read) begin
        next_st.pf_active = 1'b1;
      end
    end else if (st.tx_valid && cmpl_release) begin
      next_st.tx_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st     <= '0;
      st.opt <= BTO_OPT_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Completion release holds on the per-transaction parity wait options
  always_comb begin
    if (!st.tx_valid) begin
      cmpl_release = 1'b0;
    end else if (st.tx_read) begin
      cmpl_release = !st.tx_opt[BTO_RD_PAR_BIT] || par_received;
    end else begin
      cmpl_release = !st.tx_opt[BTO_WR_PERR_BIT] || perr_known;
    end
  end

  assign reg_rdata       = st.rdata;
  assign fwd_gen_parity  = st.tx_opt[BTO_GEN_PAR_BIT];
  assign rd_out_of_order = st.tx_opt[BTO_OOO_BIT];
  assign rd_start_ok     = !st.opt[BTO_RD_MIN_BIT] || (buf_free_dw >= prefetch_dw);
  assign pf_stop         = st.pf_stop;
  assign conv_64         = st.conv;
  assign mwi_pass        = st.mwi_pass;
  assign mwi_as_mw       = st.mwi_mw;
  assign mwi_retry       = st.mwi_retry;
  assign lock_en_pri     = st.opt[BTO_PLOCK_BIT];
  assign lock_en_sec     = st.opt[BTO_SLOCK_BIT];

  property p_rd_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      st.tx_valid && st.tx_read && st.tx_opt[BTO_RD_PAR_BIT] && !par_received
      |-> !cmpl_release;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read released before PAR");

  property p_wr_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      st.tx_valid && !st.tx_read && st.tx_opt[BTO_WR_PERR_BIT] && !perr_known
      |-> !cmpl_release;
  endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write released before PERR");

  property p_step;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cfg0_start && !cfg0_busy && stp.count == 3'h3 && $stable(st.opt)
      ##1 clk_en [*3] |-> cfg0_frame_go;
  endproperty
  a_step: assert property (p_step) else $error("FRAME step count wrong");

  property p_step0;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cfg0_start && !cfg0_busy && stp.count == 3'h0 |-> cfg0_frame_go;
  endproperty
  a_step0: assert property (p_step0) else $error("zero step not immediate");

  property p_mwi_retry;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && txn_accept && txn_is_mwi && !st.opt[BTO_MWI_BIT] &&
      buf_free_dw < BTO_CACHE_LINE_DW |=> mwi_retry && !mwi_pass;
  endproperty
  a_mwi_retry: assert property (p_mwi_retry) else $error("MWI not retried");

  property p_mwi_mw;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && txn_accept && txn_is_mwi && st.opt[BTO_MWI_BIT] &&
      buf_free_dw < BTO_CACHE_LINE_DW |=> mwi_as_mw && !mwi_retry;
  endproperty
  a_mwi_mw: assert property (p_mwi_mw) else $error("MWI not downgraded");

  property p_conv_off;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && txn_accept && !st.opt[BTO_F64_LO_BIT] && !st.opt[BTO_F64_HI_BIT]
      |=> !conv_64;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("conversion while off");

  property p_rdmin;
    @(posedge clk_sys) disable iff (!rst_n)
      st.opt[BTO_RD_MIN_BIT] && buf_free_dw < prefetch_dw |-> !rd_start_ok;
  endproperty
  a_rdmin: assert property (p_rdmin) else $error("read start without space");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && !txn_accept |=> $stable(fwd_gen_parity) && $stable(rd_out_of_order);
  endproperty
  a_hold: assert property (p_hold) else $error("queued options changed");

  property p_lock;
    @(posedge clk_sys) $rose(rst_n) |-> lock_en_pri && !lock_en_sec;
  endproperty
  a_lock: assert property (p_lock) else $error("lock reset value wrong");

  property p_mwi_pass;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && txn_accept && txn_is_mwi && buf_free_dw >= BTO_CACHE_LINE_DW
      |=> mwi_pass && !mwi_as_mw && !mwi_retry;
  endproperty
  a_mwi_pass: assert property (p_mwi_pass) else $error("MWI held despite space");

  property p_mwi_none;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && txn_accept && !txn_is_mwi |=> !mwi_pass && !mwi_as_mw && !mwi_retry;
  endproperty
  a_mwi_none: assert property (p_mwi_none) else $error("MWI result on plain cycle");

  property p_conv_both;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && txn_accept && st.opt[BTO_F64_LO_BIT] && !st.opt[BTO_F64_HI_BIT] &&
      txn_is_32 && txn_tgt_64 && txn_is_read && txn_prefetch |=> conv_64;
  endproperty
  a_conv_both: assert property (p_conv_both) else $error("conversion missed");

  property p_conv_narrow;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && txn_accept && !(txn_is_32 && txn_tgt_64) |=> !conv_64;
  endproperty
  a_conv_narrow: assert property (p_conv_narrow) else $error("narrow cycle converted");

  property p_pf_flow;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && flow_through |=> !pf_stop;
  endproperty
  a_pf_flow: assert property (p_pf_flow) else $error("prefetch stop after flow-through");

  property p_pf_off;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && txn_accept && !st.tx_opt[BTO_PF_EARLY_BIT] |=> !pf_stop;
  endproperty
  a_pf_off: assert property (p_pf_off) else $error("prefetch stop while disabled");

  property p_latch;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && txn_accept |=> fwd_gen_parity == $past(st.opt[BTO_GEN_PAR_BIT]) &&
      rd_out_of_order == $past(st.opt[BTO_OOO_BIT]);
  endproperty
  a_latch: assert property (p_latch) else $error("options not latched at accept");

  property p_lock_wr;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && reg_wr && reg_addr == BTO_OPT_OFFSET |=> lock_en_pri == $past(reg_wdata[13]) &&
      lock_en_sec == $past(reg_wdata[14]);
  endproperty
  a_lock_wr: assert property (p_lock_wr) else $error("lock enable not written");

  property p_step_busy;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && cfg0_start && !cfg0_busy && stp.count != 3'h0 |=> cfg0_busy;
  endproperty
  a_step_busy: assert property (p_step_busy) else $error("step timer not busy");

  property p_freeze;
    @(posedge clk_sys) disable iff (!rst_n)
      !clk_en |=> $stable(st.tx_opt) && $stable(st.opt);
  endproperty
  a_freeze: assert property (p_freeze) else $error("options moved while frozen");
endmodule // bto_options

// file: src/bto_pkg.sv
package bto_pkg;
  localparam logic [7:0]  BTO_OPT_OFFSET     = 8'h46;
  localparam logic [15:0] BTO_OPT_RESET      = 16'h2000;
  localparam logic [15:0] BTO_OPT_WMASK      = 16'hfe7f;
  localparam int          BTO_WR_PERR_BIT    = 0;
  localparam int          BTO_RD_PAR_BIT     = 1;
  localparam int          BTO_OOO_BIT        = 2;
  localparam int          BTO_GEN_PAR_BIT    = 3;
  localparam int          BTO_STEP_LSB       = 4;
  localparam int          BTO_STEP_W         = 3;
  localparam int          BTO_PF_EARLY_BIT   = 9;
  localparam int          BTO_RD_MIN_BIT     = 10;
  localparam int          BTO_F64_LO_BIT     = 11;
  localparam int          BTO_MWI_BIT        = 12;
  localparam int          BTO_PLOCK_BIT      = 13;
  localparam int          BTO_SLOCK_BIT      = 14;
  localparam int          BTO_F64_HI_BIT     = 15;
  localparam logic [7:0]  BTO_STATUS_OFFSET  = 8'h50;
  localparam logic [8:0]  BTO_CACHE_LINE_DW  = 9'h008;
endpackage

// file: src/bto_step_if.sv
`timescale 1ns/10ps
interface bto_step_if;
  logic       start;
  logic [2:0] count;
  logic       frame_go;
  logic       busy;
  modport ctrl (output start, output count, input frame_go, input busy);
  modport tmr  (input start, input count, output frame_go, output busy);
endinterface

// file: src/bto_step_timer.sv
`timescale 1ns/10ps
module bto_step_timer
  import bto_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  input  wire logic  clk_en,
  bto_step_if.tmr    stp
);
  typedef struct packed {
    logic       busy;
    logic [2:0] left;
  } bto_tmr_t;

  bto_tmr_t st, next_st;
  logic     go;

  always_comb begin
    next_st = st;
    go      = 1'b0;
    if (!st.busy && stp.start) begin
      if (stp.count == 3'h0) begin
        go = 1'b1;
      end else begin
        next_st.busy = 1'b1;
        next_st.left = stp.count;
      end
    end else if (st.busy) begin
      if (st.left == 3'h1) begin
        go           = 1'b1;
        next_st.busy = 1'b0;
      end
      next_st.left = st.left - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign stp.frame_go = go & clk_en;
  assign stp.busy     = st.busy;
endmodule // bto_step_timer

// file: sim/bto_far_model.sv
`timescale 1ns/10ps
module bto_far_model #(
  parameter int LAT = 3
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic txn_accept,
  output logic      perr_known,
  output logic      par_received
);
  logic [3:0] cnt;
  // Target status lags every accepted cycle by LAT clocks, so an early release shows
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt <= 4'h0;
    else if (txn_accept) cnt <= 4'(LAT);
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  assign perr_known   = (cnt == 4'h0);
  assign par_received = (cnt == 4'h0);
endmodule // bto_far_model

// file: sim/bto_options_tb.sv
`timescale 1ns/10ps
module bto_options_tb;
  import bto_pkg::*;
  logic        clk_sys, rst_n, reg_wr, reg_rd, txn_accept, cfg0_start, clk_en, flow_through;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        txn_to_sec, txn_is_read, txn_is_32, txn_prefetch, txn_posted, txn_is_mwi;
  logic        txn_tgt_64, perr_known, par_received, cfg0_frame_go, cfg0_busy, cmpl_release;
  logic        fwd_gen_parity, rd_out_of_order, rd_start_ok, pf_stop, conv_64;
  logic        mwi_pass, mwi_as_mw, mwi_retry, lock_en_pri, lock_en_sec;
  logic [8:0]  buf_free_dw, prefetch_dw;
  int          fails, check_count, n;

  bto_options i_dut (.clk_sys, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .txn_accept, .txn_to_sec, .txn_is_read, .txn_is_32, .txn_prefetch, .txn_posted,
    .txn_is_mwi, .txn_tgt_64, .buf_free_dw, .prefetch_dw, .flow_through, .perr_known,
    .par_received, .cfg0_start, .cfg0_frame_go, .cfg0_busy, .cmpl_release, .fwd_gen_parity,
    .rd_out_of_order, .rd_start_ok, .pf_stop, .conv_64, .mwi_pass, .mwi_as_mw, .mwi_retry,
    .lock_en_pri, .lock_en_sec);
  bto_far_model #(.LAT(3)) i_far (.clk_sys, .rst_n, .txn_accept, .perr_known, .par_received);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic acc(input logic [6:0] f);
    @(posedge clk_sys);
    {txn_to_sec, txn_is_read, txn_is_32, txn_prefetch, txn_posted, txn_is_mwi, txn_tgt_64} <= f;
    txn_accept <= 1'b1;
    @(posedge clk_sys);
    txn_accept <= 1'b0;
    #1;
  endtask
  task automatic mwi(input logic [15:0] o, input logic [8:0] f, input logic [2:0] e);
    wr(BTO_OPT_OFFSET, o);
    @(posedge clk_sys);
    buf_free_dw <= f;
    acc(7'b0000110);
    chk({13'h0000, mwi_pass, mwi_as_mw, mwi_retry}, {13'h0000, e});
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    {rst_n, reg_wr, reg_rd, txn_accept, cfg0_start, reg_addr, reg_wdata} = '0;
    {txn_to_sec, txn_is_read, txn_is_32, txn_prefetch, txn_posted, txn_is_mwi, txn_tgt_64} = '0;
    {clk_en, flow_through} = 2'b10;
    buf_free_dw = 9'h008;
    prefetch_dw = 9'h008;
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(BTO_OPT_OFFSET, 16'h2000);
    chk(lock_en_pri, 1'b1);
    chk(lock_en_sec, 1'b0);
    wr(BTO_OPT_OFFSET, 16'hffff);
    rd(BTO_OPT_OFFSET, 16'hfe7f);
    chk(lock_en_sec, 1'b1);
    rd(8'h10, 16'h0000);
    wr(BTO_OPT_OFFSET, 16'h0000);
    tick();
    chk(lock_en_pri, 1'b0);
    for (int s = 0; s < 8; s++) begin
      wr(BTO_OPT_OFFSET, 16'(s << BTO_STEP_LSB));
      @(posedge clk_sys);
      cfg0_start <= 1'b1;
      #1;
      n = 0;
      while (cfg0_frame_go !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        cfg0_start <= 1'b0;
        #1;
        n++;
      end
      chk(16'(n), 16'(s));
      chk(cfg0_busy, s != 0);
      if (n == 20) end_sim();
      @(posedge clk_sys);
      cfg0_start <= 1'b0;
      repeat (2) tick();
    end
    // Status arrives three clocks late, so release must stay low for two of them
    for (int b = 0; b < 2; b++) begin
      wr(BTO_OPT_OFFSET, 16'(1 << b));
      acc(b ? 7'b0100000 : 7'b0000000);
      repeat (2) tick();
      chk(cmpl_release, 1'b0);
      tick();
      chk(cmpl_release, 1'b1);
    end
    wr(BTO_OPT_OFFSET, 16'h000c);
    tick();
    chk(fwd_gen_parity, 1'b0);
    chk(rd_out_of_order, 1'b0);
    acc(7'b0100000);
    chk(fwd_gen_parity, 1'b1);
    chk(rd_out_of_order, 1'b1);
    wr(BTO_OPT_OFFSET, 16'h0400);
    @(posedge clk_sys);
    buf_free_dw <= 9'h007;
    tick();
    chk(rd_start_ok, 1'b0);
    @(posedge clk_sys);
    buf_free_dw <= 9'h008;
    tick();
    chk(rd_start_ok, 1'b1);
    for (int m = 0; m < 8; m++) begin
      wr(BTO_OPT_OFFSET, {m[1], 3'h0, m[2], 11'h000});
      // The bench initiators only ever start quadword aligned
      acc({m[0], 6'b111001});
      chk(conv_64, m[2:1] == 2'b10 || (m[1] && m[2] != m[0]));
    end
    wr(BTO_OPT_OFFSET, 16'h0800);
    acc(7'b1010101);
    chk(conv_64, 1'b1);
    acc(7'b1111000);
    chk(conv_64, 1'b0);
    wr(BTO_OPT_OFFSET, 16'h0200);
    @(posedge clk_sys);
    flow_through <= 1'b1;
    @(posedge clk_sys);
    flow_through <= 1'b0;
    acc(7'b0111001);
    chk(pf_stop, 1'b0);
    acc(7'b0111001);
    chk(pf_stop, 1'b1);
    @(posedge clk_sys);
    flow_through <= 1'b1;
    acc(7'b0111001);
    chk(pf_stop, 1'b0);
    @(posedge clk_sys);
    flow_through <= 1'b0;
    mwi(16'h0000, 9'h008, 3'b100);
    mwi(16'h1000, 9'h008, 3'b100);
    mwi(16'h1000, 9'h007, 3'b010);
    mwi(16'h0000, 9'h007, 3'b001);
    rd(BTO_STATUS_OFFSET, 16'h0020);
    // A write while frozen must leave the options untouched
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(BTO_OPT_OFFSET, 16'h6000);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(BTO_OPT_OFFSET, 16'h0000);
    chk(lock_en_sec, 1'b0);
    end_sim();
  end
endmodule // bto_options_tb
